// ==== src/vic_pkg.sv ====
// Constants shared by the vectored interrupt controller
package vic_pkg;
  // Table geometry
  localparam int VIC_NUM_IRQ = 118;
  localparam int VIC_NUM_TRAP = 8;
  localparam int VIC_NUM_VEC = 126;
  localparam logic [23:0] VIC_PRIMARY_BASE = 24'h000004;
  localparam logic [23:0] VIC_ALT_OFFSET = 24'h000100;
  localparam logic [6:0] VIC_FIRST_IRQ_VEC = 7'h08;
  localparam logic [23:0] VIC_RESET_PC = 24'h000000;
  // Vector numbers of named sources
  localparam logic [6:0] VIC_VEC_EXT_ZERO = 7'h08;
  localparam logic [6:0] VIC_VEC_SERIAL_RX = 7'h13;
  localparam logic [6:0] VIC_VEC_NONE = 7'h00;
  // Priority levels
  localparam logic [3:0] VIC_TRAP_LEVEL = 4'h8;
  localparam logic [2:0] VIC_LEVEL_OFF = 3'h0;
  // Fixed entry and return latency in cycles
  localparam int VIC_ENTRY_CYCLES = 5;
  localparam int VIC_RETURN_CYCLES = 5;
  // Sequencer states
  typedef enum logic [1:0] {
    VIC_IDLE = 2'b00,
    VIC_FETCH = 2'b01,
    VIC_ENTER = 2'b10,
    VIC_RETURN = 2'b11
  } vic_state_t;
endpackage

// ==== src/vic_vector_rom.sv ====
`timescale 1ns/100ps
// Vector table memory: both tables, word addressed, registered read
module vic_vector_rom
  import vic_pkg::*;
#(
  parameter int DEPTH = 2 * VIC_NUM_VEC
) (
  input wire logic clock,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic [7:0] wr_index,
  input wire logic [23:0] wr_data,
  input wire logic [7:0] rd_index,
  output logic [23:0] rd_data
);
  // Handler addresses, loaded by the program-memory writer
  logic [23:0] mem [0:DEPTH-1];
  // Write port and registered read port
  always_ff @(posedge clock) begin
    if (clk_en) begin
      if (wr_en) begin
        mem[wr_index] <= wr_data;
      end
      rd_data <= mem[rd_index];
    end
  end
endmodule

// ==== src/vic_core.sv ====
`timescale 1ns/100ps
// Vectored interrupt controller: flags, arbitration, vector fetch, entry sequencer
//
// Overview of operation
// - Merge all requests into one CPU request
// - Primary table at 000004h, 126 entries
// - Entry gives 24-bit handler address to CPU
// - Every source owns a distinct table slot
// - Higher level wins; trap vectors 1-4 first
// - Seven user-selectable priority levels
// - Same level resolved by vector order
// - Fixed entry and return latencies
// - 21 sources and 4 traps implemented
// - Alternate select bit picks alternate table
// - Alternate entry sits 0x100 above primary
// - Request number is vector minus eight
// - Serial receive is request 11, vector 19
// - Reset clears state, program counter zero
// - Request flags stay set until cleared
// - Per-source level; level zero disables
// - Latch pending vector and level fields
module vic_core
  import vic_pkg::*;
#(
  parameter int NIRQ = VIC_NUM_IRQ,
  parameter logic [NIRQ-1:0] IRQ_IMPL = 118'h2_0000_0000_20db_3fef,
  parameter logic [VIC_NUM_TRAP-1:0] TRAP_IMPL = 8'h1e
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic [NIRQ-1:0] irq_event,
  input wire logic [NIRQ-1:0] irq_flag_clear,
  input wire logic [NIRQ-1:0] irq_enable,
  input wire logic [3*NIRQ-1:0] irq_level,
  input wire logic [VIC_NUM_TRAP-1:0] trap_event,
  input wire logic [VIC_NUM_TRAP-1:0] trap_clear,
  input wire logic alt_table_select,
  input wire logic [3:0] cpu_level,
  input wire logic int_ack,
  input wire logic int_return,
  input wire logic tbl_wr_en,
  input wire logic [7:0] tbl_wr_index,
  input wire logic [23:0] tbl_wr_data,
  output logic [NIRQ-1:0] request_flag_regs,
  output logic [VIC_NUM_TRAP-1:0] trap_flags,
  output logic cpu_int_req,
  output logic [6:0] pending_vector_field,
  output logic [3:0] pending_level_field,
  output logic [23:0] handler_addr,
  output logic handler_valid,
  output logic resume_pulse,
  output logic [23:0] reset_pc
);
  // Sequencer state and counter
  vic_state_t state, next_state;
  logic [2:0] count, next_count;
  logic [NIRQ-1:0] next_flags;
  logic [VIC_NUM_TRAP-1:0] next_traps;
  logic next_req, next_valid, next_resume;
  logic [6:0] next_vec, win_vec;
  logic [3:0] next_lvl, win_lvl;
  logic [23:0] next_handler;
  logic win_any;
  logic [7:0] rom_index;
  logic [23:0] rom_data;

  // Sticky flags; set beats a simultaneous clear
  // Set-wins flags
  always_comb begin
    next_flags = (request_flag_regs & ~irq_flag_clear | irq_event) & IRQ_IMPL;
    next_traps = (trap_flags & ~trap_clear | trap_event) & TRAP_IMPL;
  end

  // Arbiter: highest level, ties to lowest vector; traps above all
  // Reverse order scan
  always_comb begin
    win_any = 1'b0;
    win_vec = VIC_VEC_NONE;
    win_lvl = 4'h0;
    // Scan from highest vector down so the lowest wins equal levels
    // Tie break by vector
    for (int i = NIRQ - 1; i >= 0; i--) begin
      if (request_flag_regs[i] && irq_enable[i] && irq_level[3*i +: 3] != VIC_LEVEL_OFF &&
          {1'b0, irq_level[3*i +: 3]} >= win_lvl) begin
        win_any = 1'b1;
        win_lvl = {1'b0, irq_level[3*i +: 3]};
        // Vector is request number plus eight
        // Request 11 lands on vector 19
        win_vec = VIC_FIRST_IRQ_VEC + 7'(i);
      end
    end
    for (int t = VIC_NUM_TRAP - 1; t >= 0; t--) begin
      if (trap_flags[t]) begin
        win_any = 1'b1;
        win_lvl = VIC_TRAP_LEVEL;
        win_vec = 7'(t);
      end
    end
    if (win_lvl <= cpu_level) begin
      win_any = 1'b0;
    end
  end

  // Table index: one slot per vector, alternate half above
  // Alternate offset applied
  always_comb begin
    rom_index = alt_table_select ? 8'(VIC_NUM_VEC) + {1'b0, pending_vector_field}
                                 : {1'b0, pending_vector_field};
  end

  // Vector memory, one word per distinct slot
  // Unique slot per source
  vic_vector_rom u_rom (
    .clock(clock),
    .clk_en(clk_en),
    .wr_en(tbl_wr_en),
    .wr_index(tbl_wr_index),
    .wr_data(tbl_wr_data),
    .rd_index(rom_index),
    .rd_data(rom_data)
  );

  // Sequencer next-state logic
  always_comb begin
    next_state = state;
    next_count = count;
    next_req = 1'b0;
    next_valid = 1'b0;
    next_resume = 1'b0;
    next_vec = pending_vector_field;
    next_lvl = pending_level_field;
    next_handler = handler_addr;
    case (state)
      VIC_IDLE: begin
        next_req = win_any;
        if (win_any) begin
          next_vec = win_vec;
          next_lvl = win_lvl;
        end
        if (cpu_int_req && int_ack) begin
          next_state = VIC_FETCH;
          next_count = 3'h1;
          next_req = 1'b0;
        end
      end
      VIC_FETCH: begin
        // Wait one cycle for the registered table read
        next_state = VIC_ENTER;
        next_count = count + 3'h1;
      end
      VIC_ENTER: begin
        next_count = count + 3'h1;
        if (count == 3'(VIC_ENTRY_CYCLES - 1)) begin
          next_handler = rom_data;
          next_valid = 1'b1;
          next_state = VIC_RETURN;
          next_count = 3'h0;
        end
      end
      VIC_RETURN: begin
        if (count != 3'h0 || int_return) begin
          next_count = count + 3'h1;
        end
        if (count == 3'(VIC_RETURN_CYCLES - 1)) begin
          next_resume = 1'b1;
          next_state = VIC_IDLE;
          next_count = 3'h0;
        end
      end
      default: begin
        next_state = VIC_IDLE;
        next_count = 3'h0;
      end
    endcase
  end

  // Register all state
  // Reset clears everything
  always_ff @(posedge clock) begin
    if (rst) begin
      state <= VIC_IDLE;
      count <= 3'h0;
      request_flag_regs <= '0;
      trap_flags <= '0;
      cpu_int_req <= 1'b0;
      pending_vector_field <= VIC_VEC_NONE;
      pending_level_field <= 4'h0;
      handler_addr <= VIC_RESET_PC;
      handler_valid <= 1'b0;
      resume_pulse <= 1'b0;
      reset_pc <= VIC_RESET_PC;
    end else if (clk_en) begin
      state <= next_state;
      count <= next_count;
      request_flag_regs <= next_flags;
      trap_flags <= next_traps;
      cpu_int_req <= next_req;
      pending_vector_field <= next_vec;
      pending_level_field <= next_lvl;
      handler_addr <= next_handler;
      handler_valid <= next_valid;
      resume_pulse <= next_resume;
      reset_pc <= VIC_RESET_PC;
    end
  end

  // Entry sequence: acknowledge then handler valid five enabled cycles later
  sequence s_ack;
    cpu_int_req && int_ack && clk_en;
  endsequence
  a_entry_latency: assert property (@(posedge clock) disable iff (rst)
    s_ack ##1 (clk_en [*4]) |=> handler_valid)
    else $error("handler not valid at fixed entry latency");
  a_level_gate: assert property (@(posedge clock) disable iff (rst)
    cpu_int_req |-> pending_level_field > $past(cpu_level))
    else $error("request at or below cpu level");
  a_flag_sticky: assert property (@(posedge clock) disable iff (rst)
    ($past(clk_en) && $past(request_flag_regs[11]) && !$past(irq_flag_clear[11]))
      |-> request_flag_regs[11])
    else $error("flag dropped without clear");
  a_set_wins: assert property (@(posedge clock) disable iff (rst)
    (clk_en && irq_event[0]) |=> request_flag_regs[0])
    else $error("event lost");
  a_no_reserved: assert property (@(posedge clock) disable iff (rst)
    (request_flag_regs & ~IRQ_IMPL) == '0 && (trap_flags & ~TRAP_IMPL) == '0)
    else $error("reserved slot flagged");
  a_trap_first: assert property (@(posedge clock) disable iff (rst)
    (cpu_int_req && |trap_flags && $stable(trap_flags)) |-> pending_level_field == VIC_TRAP_LEVEL)
    else $error("trap not preferred");
  a_vector_range: assert property (@(posedge clock) disable iff (rst)
    cpu_int_req |-> pending_vector_field < 7'(VIC_NUM_VEC))
    else $error("vector out of table");
  a_resume_latency: assert property (@(posedge clock) disable iff (rst)
    (state == VIC_RETURN && count == 3'h0 && int_return && clk_en) ##1 (clk_en [*4])
      |=> resume_pulse)
    else $error("resume not at fixed return latency");
  a_reset_pc: assert property (@(posedge clock) disable iff (rst)
    reset_pc == VIC_RESET_PC)
    else $error("reset entry not zero");
endmodule

// ==== tb/tb_cpu_model.sv ====
`timescale 1ns/100ps
// Behavioural CPU core: takes a request, enters the handler, returns
module tb_cpu_model (
  input wire logic clock,
  input wire logic go,
  input wire logic [3:0] hold_n,
  input wire logic cpu_int_req,
  input wire logic handler_valid,
  input wire logic resume_pulse,
  input wire logic [23:0] handler_addr,
  output logic int_ack = 0,
  output logic int_return = 0,
  output logic done = 0,
  output int entry_n = 0,
  output int return_n = 0,
  output logic [23:0] seen_addr = '0
);
  // Sequence step and cycle count
  int st = 0;
  int cnt = 0;
  // Acts on the falling edge so the core samples steady inputs
  always @(negedge clock) begin
    case (st)
      // Idle: optionally stall, then ack while a request stands
      0: begin
        if (!go) done <= 0;
        else if (!done && cpu_int_req) begin
          cnt <= cnt + 1;
          if (cnt >= hold_n) begin
            int_ack <= 1;
            cnt <= 0;
            st <= 1;
          end
        end
      end
      // Entry: count edges until the handler address arrives
      1: begin
        int_ack <= 0;
        cnt <= cnt + 1;
        if (handler_valid) begin
          entry_n <= cnt + 1;
          seen_addr <= handler_addr;
          int_return <= 1;
          cnt <= 0;
          st <= 2;
        end
      end
      // Return: count edges until execution resumes
      default: begin
        int_return <= 0;
        cnt <= cnt + 1;
        if (resume_pulse) begin
          return_n <= cnt + 1;
          done <= 1;
          cnt <= 0;
          st <= 0;
        end
      end
    endcase
  end
endmodule

// ==== tb/tb_top.sv ====
`timescale 1ns/100ps
// Self-checking bench for the interrupt controller core
module tb_top;
  import vic_pkg::*;
  logic clock = 0, rst = 1, clk_en = 1, alt_table_select = 0, tbl_wr_en = 0, go = 0;
  logic [117:0] irq_event = '0, irq_flag_clear = '0, irq_enable = '0, impl = '0, ef;
  logic [353:0] irq_level = '0;
  logic [7:0] trap_event = '0, trap_clear = '0, tbl_wr_index = '0, trap_flags, et;
  logic [3:0] cpu_level = '0, hold_n = '0, pending_level_field;
  logic [23:0] tbl_wr_data = '0, handler_addr, reset_pc, seen_addr;
  logic [117:0] request_flag_regs;
  logic cpu_int_req, handler_valid, resume_pulse, int_ack, int_return, done;
  logic [6:0] pending_vector_field;
  logic [31:0] seed = 32'h5804, w;
  int entry_n, return_n, ev, el, k, mismatches = 0, check_count = 0;
  // Implemented request numbers
  int ids[21] = '{0, 1, 2, 3, 5, 6, 7, 8, 9, 10, 11, 12, 13, 16, 17, 19, 20, 22, 23, 29, 65};
  always #20 clock = ~clock;
  vic_core u_vic_core (.clock(clock), .rst(rst), .clk_en(clk_en), .irq_event(irq_event),
    .irq_flag_clear(irq_flag_clear), .irq_enable(irq_enable), .irq_level(irq_level),
    .trap_event(trap_event), .trap_clear(trap_clear), .alt_table_select(alt_table_select),
    .cpu_level(cpu_level), .int_ack(int_ack), .int_return(int_return), .tbl_wr_en(tbl_wr_en),
    .tbl_wr_index(tbl_wr_index), .tbl_wr_data(tbl_wr_data),
    .request_flag_regs(request_flag_regs), .trap_flags(trap_flags),
    .cpu_int_req(cpu_int_req), .pending_vector_field(pending_vector_field),
    .pending_level_field(pending_level_field), .handler_addr(handler_addr),
    .handler_valid(handler_valid), .resume_pulse(resume_pulse), .reset_pc(reset_pc));
  tb_cpu_model u_tb_cpu_model (.clock(clock), .go(go), .hold_n(hold_n),
    .cpu_int_req(cpu_int_req), .handler_valid(handler_valid), .resume_pulse(resume_pulse),
    .handler_addr(handler_addr), .int_ack(int_ack), .int_return(int_return), .done(done),
    .entry_n(entry_n), .return_n(return_n), .seen_addr(seen_addr));
  // Xorshift source of stimulus
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Table word loaded for a vector: tagged byte address of its slot
  function automatic logic [23:0] entry(int v, bit alt);
    return (VIC_PRIMARY_BASE + 24'(2 * v) + (alt ? VIC_ALT_OFFSET : 24'h0)) ^ 24'h5a0000;
  endfunction
  task automatic check(string name, logic [127:0] seen, logic [127:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic tally_and_finish();
    if (mismatches == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Reference arbiter: traps first, then highest level, ties to lowest vector
  task automatic winner();
    ev = -1;
    el = 0;
    for (int t = 7; t >= 0; t--) if (et[t]) begin ev = t; el = 8; end
    if (ev < 0) for (int i = 117; i >= 0; i--) begin
      k = irq_level[3*i+:3];
      if (ef[i] && irq_enable[i] && k > cpu_level && k >= el) begin ev = i + 8; el = k; end
    end
  endtask
  // One pass: raise events, check flags and request, take it, clear flags
  task automatic run();
    ef = irq_event & impl;
    et = trap_event & 8'h1e;
    winner();
    @(negedge clock);
    irq_event = '0;
    trap_event = '0;
    @(negedge clock);
    check("flags", request_flag_regs, ef);
    check("traps", trap_flags, et);
    check("req", cpu_int_req, ev >= 0);
    if (ev >= 0) begin
      check("vector", pending_vector_field, ev);
      check("level", pending_level_field, el);
      go = 1;
      for (k = 0; k < 60 && done !== 1; k++) @(negedge clock);
      if (done !== 1) begin
        mismatches++;
        tally_and_finish();
      end
      go = 0;
      check("entry", entry_n, VIC_ENTRY_CYCLES);
      check("return", return_n, VIC_RETURN_CYCLES);
      check("addr", seen_addr, entry(ev, alt_table_select));
      check("held", request_flag_regs, ef);
    end
    irq_flag_clear = '1;
    trap_clear = '1;
    @(negedge clock);
    irq_flag_clear = '0;
    trap_clear = '0;
    @(negedge clock);
    check("cleared", request_flag_regs, 0);
  endtask
  initial begin
    foreach (ids[j]) impl[ids[j]] = 1;
    repeat (10) @(negedge clock);
    rst = 0;
    check("reset_pc", reset_pc, VIC_RESET_PC);
    check("reset_req", cpu_int_req, 0);
    // Load both tables, alternate slots at 126 plus vector
    for (k = 0; k < 252; k++) begin
      tbl_wr_en = 1;
      tbl_wr_index = 8'(k);
      tbl_wr_data = entry(k % 126, k >= 126);
      @(negedge clock);
    end
    tbl_wr_en = 0;
    // Frozen core ignores events while the clock enable is low
    clk_en = 0;
    irq_event[12] = 1;
    repeat (3) @(negedge clock);
    check("frozen", request_flag_regs, 0);
    check("frozen_req", cpu_int_req, 0);
    clk_en = 1;
    irq_event = '0;
    // Serial receive against a later source at equal level
    irq_enable = '1;
    irq_level = '1;
    irq_event[11] = 1;
    irq_event[19] = 1;
    run();
    // Serial receive alone with the CPU already at the top user level
    cpu_level = 4'h7;
    irq_event[11] = 1;
    run();
    // Traps, including the reserved one, above the CPU level
    trap_event = 8'h1f;
    irq_event[0] = 1;
    run();
    // Random mixes of events, levels, enables and tables
    repeat (60) begin
      for (int i = 0; i < 118; i++) begin
        w = rnd();
        irq_level[3*i+:3] = w[2:0];
        irq_enable[i] = w[3];
        irq_event[i] = w[4] & w[5];
      end
      w = rnd();
      trap_event = (w[3:0] == 0) ? w[23:16] : 8'h00;
      cpu_level = {1'b0, w[10:8]};
      alt_table_select = w[11];
      hold_n = w[15:12];
      run();
    end
    tally_and_finish();
  end
endmodule
